// File: include/coe_pkg.sv
/*
 Constants, field layouts and reset values for the clock output enable bytes
 and their two-wire serial access path.
 Assumes a single 100 MHz core clock and an asynchronous active-high reset.
*/
// Operation
// - Disabled clock output held low, not toggling
// - Bus byte bit 7 reads inverted strap
// - Bus byte bits 6,4:0 enable, reset one
// - Memory byte bits 7:0 enable, reset one
// - Reserved byte resets to bits 2,1 set
// - Write: command, count, then bytes ascending
// - Read: count first, then bytes ascending
// - All bytes take defaults at reset
`default_nettype none
package coe_pkg;

   // ----------------------------------------
   // Register offsets (byte index in a block transfer)
   // ----------------------------------------
   localparam logic [3:0] COE_OFS_BUS_EN = 4'h2;
   localparam logic [3:0] COE_OFS_MEM_EN = 4'h4;
   localparam logic [3:0] COE_OFS_RSVD = 4'h6;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int COE_BIT_STRAP = 7;
   localparam int COE_BIT_FREE = 6;
   localparam int COE_BIT_BUS_RSVD = 5;
   localparam logic [4:0] COE_BUS_EN_RST = 5'h1F;
   localparam logic COE_FREE_EN_RST = 1'h1;
   localparam logic COE_BUS_RSVD_VAL = 1'h1;
   localparam logic [7:0] COE_MEM_EN_RST = 8'hFF;
   localparam logic [7:0] COE_RSVD_RST = 8'h06;

   // ----------------------------------------
   // Serial access constants
   // ----------------------------------------
   localparam logic [7:0] COE_ADDR_WR = 8'hD2;
   localparam logic [7:0] COE_ADDR_RD = 8'hD3;
   localparam logic [7:0] COE_BLOCK_COUNT = 8'h07;
   localparam logic [3:0] COE_HDR_BYTES = 4'h2;
   localparam logic [3:0] COE_BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] COE_STRAP_SETTLE = 2'h3;

   typedef enum logic [2:0] {
      COE_ST_IDLE = 3'b000,
      COE_ST_RX = 3'b001,
      COE_ST_RX_ACK = 3'b010,
      COE_ST_TX = 3'b011,
      COE_ST_TX_ACK = 3'b100,
      COE_ST_TX_NEXT = 3'b101
   } coe_state_t;

   typedef struct packed {
      logic free_en;
      logic [4:0] bus_en;
   } coe_bus_en_t;

endpackage
`default_nettype wire

// File: logic/coe_clock_gate.sv
/*
 Glitch-free gate for a group of outputs driven from one source clock.
 Assumes the source clock is asynchronous to clock_in and much slower.
*/
`timescale 1ns/100ps
`default_nettype none
module coe_clock_gate #(
   parameter int WIDTH = 8
) (
   input wire logic clock_in,               // Core clock
   input wire logic rst_in,                 // Async reset, high
   input wire logic src_clk_in,             // Source clock pin
   input wire logic [WIDTH-1:0] enable_in,  // Requested enables
   output logic [WIDTH-1:0] clk_out         // Gated outputs
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic src_q;
   logic src_d;
   logic [WIDTH-1:0] en_act_q;
   logic [WIDTH-1:0] en_act_d;
   logic [WIDTH-1:0] out_q;
   logic [WIDTH-1:0] out_d;

   always_comb begin
      sync_d = {sync_q[1:0], src_clk_in};
      src_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : src_q;
      en_act_d = src_q ? en_act_q : enable_in;
      out_d = src_q ? en_act_q : '0;
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         // Parked high and closed: no runt pulse after reset
         sync_q <= 3'h7;
         src_q <= 1'h1;
         en_act_q <= '0;
         out_q <= '0;
      end else begin
         sync_q <= sync_d;
         src_q <= src_d;
         en_act_q <= en_act_d;
         out_q <= out_d;
      end
   end

   assign clk_out = out_q;
endmodule // coe_clock_gate
`default_nettype wire

// File: logic/coe_clock_enable.sv
/*
 Bus-clock, memory-clock and reserved control bytes with a two-wire serial
 slave for block writes and block reads, plus output gating.
 Assumes serial pins and source clocks are asynchronous; open-drain data is
 resolved outside from sda_oe_out.
*/
`timescale 1ns/100ps
`default_nettype none
module coe_clock_enable
   import coe_pkg::*;
(
   input wire logic clock_in,                    // Core clock 100 MHz
   input wire logic rst_in,                      // Async reset, high
   input wire logic scl_in,                      // Serial clock pin
   input wire logic sda_in,                      // Serial data pin level
   output logic sda_out,                         // Serial data drive value
   output logic sda_oe_out,                      // High pulls data low
   input wire logic freq_strap0_in,              // Lowest frequency strap
   input wire logic bus_src_clk_in,              // Bus clock source
   input wire logic mem_src_clk_in,              // Memory clock source
   output logic [4:0] bus_clock_out,             // Gated bus clocks
   output logic free_running_bus_clock_out,      // Gated free-running bus clock
   output logic [7:0] mem_clock_out              // Gated memory clocks
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [2:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d, strap_sync_q, strap_sync_d;
   logic scl_f_q, scl_f_d, sda_f_q, sda_f_d, scl_p_q, scl_p_d, sda_p_q, sda_p_d;
   logic [1:0] settle_q, settle_d;
   logic strap_done_q, strap_done_d, strap_q, strap_d;
   coe_state_t st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] bitcnt_q, bitcnt_d, bytenum_q, bytenum_d, txptr_q, txptr_d;
   logic addr_ph_q, addr_ph_d, is_rd_q, is_rd_d, oe_q, oe_d;
   coe_bus_en_t bus_q, bus_d;
   logic [7:0] mem_q, mem_d, rsvd_q, rsvd_d;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [3:0] wr_idx;
   logic [5:0] bus_gate;

   function automatic logic [7:0] read_byte(input logic [3:0] idx, input coe_bus_en_t b,
                                           input logic [7:0] m, input logic [7:0] r, input logic s);
      case (idx)
         COE_OFS_BUS_EN: read_byte = {~s, b.free_en, COE_BUS_RSVD_VAL, b.bus_en};
         COE_OFS_MEM_EN: read_byte = m;
         COE_OFS_RSVD: read_byte = r;
         default: read_byte = 8'h00;
      endcase
   endfunction

   // ----------------------------------------
   // Pin filtering and strap capture
   // ----------------------------------------
   always_comb begin
      scl_sync_d = {scl_sync_q[1:0], scl_in};
      sda_sync_d = {sda_sync_q[1:0], sda_in};
      strap_sync_d = {strap_sync_q[1:0], freq_strap0_in};
      scl_f_d = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_f_q;
      sda_f_d = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;
      scl_p_d = scl_f_q;
      sda_p_d = sda_f_q;
      settle_d = (settle_q == COE_STRAP_SETTLE) ? settle_q : settle_q + 2'h1;
      strap_done_d = strap_done_q;
      strap_d = strap_q;
      if (!strap_done_q && settle_q == COE_STRAP_SETTLE && strap_sync_q[1] == strap_sync_q[2]) begin
         strap_d = strap_sync_q[2];
         strap_done_d = 1'b1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         strap_sync_q <= 3'h0;
         scl_f_q <= 1'h1;
         sda_f_q <= 1'h1;
         scl_p_q <= 1'h1;
         sda_p_q <= 1'h1;
         settle_q <= 2'h0;
         strap_done_q <= 1'h0;
         strap_q <= 1'h0;
      end else begin
         scl_sync_q <= scl_sync_d;
         sda_sync_q <= sda_sync_d;
         strap_sync_q <= strap_sync_d;
         scl_f_q <= scl_f_d;
         sda_f_q <= sda_f_d;
         scl_p_q <= scl_p_d;
         sda_p_q <= sda_p_d;
         settle_q <= settle_d;
         strap_done_q <= strap_done_d;
         strap_q <= strap_d;
      end
   end

   assign scl_rise = scl_f_q & ~scl_p_q;
   assign scl_fall = ~scl_f_q & scl_p_q;
   assign start_det = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
   assign stop_det = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
   assign wr_idx = bytenum_q - COE_HDR_BYTES;

   // ----------------------------------------
   // Serial slave and control bytes
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      bitcnt_d = bitcnt_q;
      bytenum_d = bytenum_q;
      txptr_d = txptr_q;
      addr_ph_d = addr_ph_q;
      is_rd_d = is_rd_q;
      oe_d = oe_q;
      bus_d = bus_q;
      mem_d = mem_q;
      rsvd_d = rsvd_q;
      if (start_det) begin
         st_d = COE_ST_RX;
         addr_ph_d = 1'b1;
         bitcnt_d = 4'h0;
         bytenum_d = 4'h0;
         oe_d = 1'b0;
      end else if (stop_det) begin
         st_d = COE_ST_IDLE;
         oe_d = 1'b0;
      end else begin
         unique case (st_q)
            COE_ST_IDLE: begin
               oe_d = 1'b0;
            end
            COE_ST_RX: begin
               if (scl_rise && bitcnt_q < COE_BITS_PER_BYTE) begin
                  sh_d = {sh_q[6:0], sda_f_q};
                  bitcnt_d = bitcnt_q + 4'h1;
               end else if (scl_fall && bitcnt_q == COE_BITS_PER_BYTE) begin
                  bitcnt_d = 4'h0;
                  if (addr_ph_q) begin
                     if (sh_q == COE_ADDR_WR || sh_q == COE_ADDR_RD) begin
                        is_rd_d = sh_q[0];
                        oe_d = 1'b1;
                        st_d = COE_ST_RX_ACK;
                     end else begin
                        st_d = COE_ST_IDLE;
                     end
                  end else begin
                     oe_d = 1'b1;
                     st_d = COE_ST_RX_ACK;
                     if (bytenum_q != 4'hF) begin
                        bytenum_d = bytenum_q + 4'h1;
                     end
                     if (bytenum_q >= COE_HDR_BYTES) begin
                        if (wr_idx == COE_OFS_BUS_EN) begin
                           bus_d.free_en = sh_q[COE_BIT_FREE];
                           bus_d.bus_en = sh_q[4:0];
                        end
                        if (wr_idx == COE_OFS_MEM_EN) begin
                           mem_d = sh_q;
                        end
                        if (wr_idx == COE_OFS_RSVD) begin
                           rsvd_d = sh_q;
                        end
                     end
                  end
               end
            end
            COE_ST_RX_ACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  st_d = COE_ST_RX;
                  if (addr_ph_q && is_rd_q) begin
                     oe_d = ~COE_BLOCK_COUNT[7];
                     sh_d = {COE_BLOCK_COUNT[6:0], 1'b0};
                     bitcnt_d = 4'h1;
                     txptr_d = 4'h0;
                     st_d = COE_ST_TX;
                  end
                  addr_ph_d = 1'b0;
               end
            end
            COE_ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt_q == COE_BITS_PER_BYTE) begin
                     oe_d = 1'b0;
                     st_d = COE_ST_TX_ACK;
                  end else begin
                     oe_d = ~sh_q[7];
                     sh_d = {sh_q[6:0], 1'b0};
                     bitcnt_d = bitcnt_q + 4'h1;
                  end
               end
            end
            COE_ST_TX_ACK: begin
               if (scl_rise) begin
                  st_d = sda_f_q ? COE_ST_IDLE : COE_ST_TX_NEXT;
               end
            end
            COE_ST_TX_NEXT: begin
               if (scl_fall) begin
                  sh_d = read_byte(txptr_q, bus_q, mem_q, rsvd_q, strap_q);
                  oe_d = ~sh_d[7];
                  sh_d = {sh_d[6:0], 1'b0};
                  bitcnt_d = 4'h1;
                  if (txptr_q != 4'hF) begin
                     txptr_d = txptr_q + 4'h1;
                  end
                  st_d = COE_ST_TX;
               end
            end
            default: begin
               st_d = COE_ST_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= COE_ST_IDLE;
         sh_q <= 8'h00;
         bitcnt_q <= 4'h0;
         bytenum_q <= 4'h0;
         txptr_q <= 4'h0;
         addr_ph_q <= 1'h0;
         is_rd_q <= 1'h0;
         oe_q <= 1'h0;
         bus_q <= '{free_en: COE_FREE_EN_RST, bus_en: COE_BUS_EN_RST};
         mem_q <= COE_MEM_EN_RST;
         rsvd_q <= COE_RSVD_RST;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         bitcnt_q <= bitcnt_d;
         bytenum_q <= bytenum_d;
         txptr_q <= txptr_d;
         addr_ph_q <= addr_ph_d;
         is_rd_q <= is_rd_d;
         oe_q <= oe_d;
         bus_q <= bus_d;
         mem_q <= mem_d;
         rsvd_q <= rsvd_d;
      end
   end

   assign sda_oe_out = oe_q;
   assign sda_out = 1'b0;

   // ----------------------------------------
   // Output gating
   // ----------------------------------------
   coe_clock_gate #(.WIDTH(6)) u_bus_gate (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .src_clk_in(bus_src_clk_in),
      .enable_in({bus_q.free_en, bus_q.bus_en}),
      .clk_out(bus_gate)
   );

   coe_clock_gate #(.WIDTH(8)) u_mem_gate (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .src_clk_in(mem_src_clk_in),
      .enable_in(mem_q),
      .clk_out(mem_clock_out)
   );

   assign bus_clock_out = bus_gate[4:0];
   assign free_running_bus_clock_out = bus_gate[5];
endmodule // coe_clock_enable
`default_nettype wire

// File: testbench/coe_clock_enable_properties.sv
/*
 Port checker for the clock output enable block.
 Assumes one core clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module coe_clock_enable_properties (
   input wire logic clock_in, // Core clock
   input wire logic rst_in, // Async reset
   input wire logic scl_in, // Serial clock
   input wire logic sda_in, // Data level
   input wire logic sda_out, // Data drive value
   input wire logic sda_oe_out, // Data pull-down
   input wire logic freq_strap0_in, // Strap
   input wire logic bus_src_clk_in, // Bus source
   input wire logic mem_src_clk_in, // Memory source
   input wire logic [4:0] bus_clock_out, // Bus clocks
   input wire logic free_running_bus_clock_out, // Free bus clock
   input wire logic [7:0] mem_clock_out // Memory clocks
);
   // ----
   // Source history for latency window
   // ----
   logic [6:0] bus_h;
   logic [6:0] mem_h;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         bus_h <= 7'h00;
         mem_h <= 7'h00;
      end else begin
         bus_h <= {bus_h[5:0], bus_src_clk_in};
         mem_h <= {mem_h[5:0], mem_src_clk_in};
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   property p_reset_quiet;
      $fell(rst_in) |-> (!sda_oe_out && !free_running_bus_clock_out && bus_clock_out == 5'h00
         && mem_clock_out == 8'h00)[*3];
   endproperty
   property p_sda_scl_low;
      $changed(sda_oe_out) |-> !scl_in;
   endproperty
   property p_bus_follow;
      bus_clock_out[0] |-> |bus_h[6:2];
   endproperty
   property p_free_follow;
      free_running_bus_clock_out |-> |bus_h[6:2];
   endproperty
   property p_mem_follow;
      mem_clock_out[7] |-> |mem_h[6:2];
   endproperty
   property p_bus_low_hold;
      (!bus_src_clk_in)[*8] |-> bus_clock_out == 5'h00;
   endproperty
   property p_bus_no_runt;
      $rose(bus_clock_out[4]) |-> bus_clock_out[4][*6];
   endproperty
   property p_mem_no_runt;
      $fell(mem_clock_out[0]) |-> (!mem_clock_out[0])[*5];
   endproperty
   property p_free_no_runt;
      $rose(free_running_bus_clock_out) |=> free_running_bus_clock_out[*5];
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
   a_sda_scl_low: assert property (p_sda_scl_low) else $error("data moved with clock high");
   a_bus_follow: assert property (p_bus_follow) else $error("bus clock high without source");
   a_free_follow: assert property (p_free_follow) else $error("free clock high without source");
   a_mem_follow: assert property (p_mem_follow) else $error("memory clock high without source");
   a_bus_low_hold: assert property (p_bus_low_hold) else $error("bus clock not low");
   a_bus_no_runt: assert property (p_bus_no_runt) else $error("short bus clock pulse");
   a_mem_no_runt: assert property (p_mem_no_runt) else $error("short memory low phase");
   a_free_no_runt: assert property (p_free_no_runt) else $error("short free clock pulse");
   c_ack: cover property ($rose(sda_oe_out));
   c_bus_off: cover property ($fell(bus_clock_out[0]));
   c_mem_on: cover property ($rose(mem_clock_out[7]));
endmodule // coe_clock_enable_properties
bind coe_clock_enable coe_clock_enable_properties chk (.clock_in(clock_in), .rst_in(rst_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
   .freq_strap0_in(freq_strap0_in), .bus_src_clk_in(bus_src_clk_in), .mem_src_clk_in(mem_src_clk_in),
   .bus_clock_out(bus_clock_out), .free_running_bus_clock_out(free_running_bus_clock_out),
   .mem_clock_out(mem_clock_out));
`default_nettype wire

// File: testbench/coe_host_model.sv
/*
 Two-wire serial host model with byte tasks.
 Assumes a pulled-up data line resolved outside; posts each result for one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module coe_host_model (
   input wire logic clock_in, // Core clock
   input wire logic sda_in, // Resolved data line
   output logic scl_out, // Serial clock
   output logic sda_oe_out, // High pulls data low
   output logic [7:0] res_out, // Byte read or ack bit
   output logic res_valid_out // Result strobe
);
   localparam int Q = 15;
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
      res_out = 8'h00;
      res_valid_out = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic bit_io(input logic b, output logic s);
      sda_oe_out = !b;
      wt(Q);
      scl_out = 1'b1;
      wt(Q);
      s = sda_in;
      wt(Q);
      scl_out = 1'b0;
      wt(Q);
   endtask
   task automatic post(input logic [7:0] v);
      res_out = v;
      res_valid_out = 1'b1;
      wt(1);
      res_valid_out = 1'b0;
   endtask
   task automatic start();
      wt(Q);
      sda_oe_out = 1'b1;
      wt(Q);
      scl_out = 1'b0;
      wt(Q);
   endtask
   task automatic stop();
      sda_oe_out = 1'b1;
      wt(Q);
      scl_out = 1'b1;
      wt(Q);
      sda_oe_out = 1'b0;
      wt(2 * Q);
   endtask
   task automatic send(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, s);
      post({7'h00, s});
   endtask
   task automatic recv(input logic ack);
      logic [7:0] v;
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      bit_io(!ack, s);
      post(v);
   endtask
endmodule // coe_host_model
`default_nettype wire

// File: testbench/tb_clock_output_enable_regs.sv
/*
 Self-checking bench for the clock output enable block.
 Assumes the host model above and a pull-up on the data line.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_clock_output_enable_regs
   import coe_pkg::*;
;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic strap = 1'b1;
   logic bus_src = 1'b0;
   logic mem_src = 1'b0;
   logic scl, host_oe, sda_oe, res_v, free_clk, sda_line, sda_drv;
   logic [7:0] res;
   logic [4:0] bus_clk;
   logic [7:0] mem_clk;
   logic [13:0] outs;
   logic [7:0] exp_q[$];
   logic [7:0] exp_reg[7];
   int fails = 0;
   int checks_done = 0;
   int seed = 32'h6CE4A8A2;
   assign sda_line = !host_oe && (sda_oe ? sda_drv : 1'b1);
   assign outs = {mem_clk, free_clk, bus_clk};
   always #5 clock_in = ~clock_in;
   always begin
      repeat (10) @(negedge clock_in);
      bus_src = ~bus_src;
   end
   always begin
      repeat (7) @(negedge clock_in);
      mem_src = ~mem_src;
   end
   coe_clock_enable dut (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_drv), .sda_oe_out(sda_oe), .freq_strap0_in(strap), .bus_src_clk_in(bus_src),
      .mem_src_clk_in(mem_src), .bus_clock_out(bus_clk), .free_running_bus_clock_out(free_clk),
      .mem_clock_out(mem_clk));
   coe_host_model host (.clock_in(clock_in), .sda_in(sda_line), .scl_out(scl), .sda_oe_out(host_oe),
      .res_out(res), .res_valid_out(res_v));
   // ----
   // Checking and closing
   // ----
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock_in) begin
      if (res_v === 1'b1) check(res, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
   end
   // ----
   // Stimulus
   // ----
   task automatic put(input logic [7:0] v, input logic [7:0] ack);
      exp_q.push_back(ack);
      host.send(v);
   endtask
   task automatic rst(input logic s);
      strap = s;
      rst_in = 1'b1;
      repeat (20) @(negedge clock_in);
      rst_in = 1'b0;
      exp_reg = '{8'h00, 8'h00, {~s, 7'h7F}, 8'h00, 8'hFF, 8'h00, 8'h06};
      repeat (10) @(negedge clock_in);
   endtask
   task automatic rd_block();
      host.start();
      put(COE_ADDR_RD, 8'h00);
      exp_q.push_back(COE_BLOCK_COUNT);
      host.recv(1'b1);
      for (int i = 0; i < 7; i++) begin
         exp_q.push_back(exp_reg[i]);
         host.recv(i < 6);
      end
      host.stop();
   endtask
   task automatic wr_block(input int n);
      logic [7:0] v;
      host.start();
      put(COE_ADDR_WR, 8'h00);
      put(8'($random(seed)), 8'h00);
      put(8'($random(seed)), 8'h00);
      for (int i = 0; i < n; i++) begin
         v = 8'($random(seed));
         if (i == 2) exp_reg[2] = {exp_reg[2][7], v[6], 1'b1, v[4:0]};
         if (i == 4) exp_reg[4] = v;
         put(v, 8'h00);
      end
      host.stop();
   endtask
   task automatic gate();
      int hi[14];
      int lo[14];
      logic [13:0] en;
      en = {exp_reg[4], exp_reg[2][6], exp_reg[2][4:0]};
      hi = '{default: 0};
      lo = '{default: 0};
      repeat (400) begin
         @(negedge clock_in);
         for (int i = 0; i < 14; i++) begin
            hi[i] += int'(outs[i] === 1'b1);
            lo[i] += int'(outs[i] === 1'b0);
         end
      end
      for (int i = 0; i < 14; i++) begin
         check(8'(hi[i] != 0), 8'(en[i]));
         check(8'(lo[i] != 0), 8'h01);
      end
   endtask
   initial begin
      rst(1'b1);
      rd_block();
      gate();
      host.start();
      put(8'hA0, 8'h01);
      host.stop();
      for (int k = 0; k < 2; k++) begin
         wr_block(k ? 3 : 6);
         rd_block();
         gate();
      end
      rst(1'b0);
      rd_block();
      gate();
      conclude();
   end
   initial begin
      #600us;
      fails++;
      conclude();
   end
endmodule // tb_clock_output_enable_regs
`default_nettype wire
